// >>> logic/pm_lines.sv
// power control lines, nmi combining and automatic power-on
`timescale 1ns/1ps
module pm_lines
    import pm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire pm_iobus_t io_bus,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe_n,
    input wire logic [LINES-1:0] power_ctl_line_in,
    output logic [LINES-1:0] power_ctl_line_out,
    output logic [LINES-1:0] power_ctl_line_oe_n,
    input wire logic ext_nmi_in_a,
    input wire logic ext_nmi_in_b,
    input wire logic minute_tick,
    input wire logic ring_in_n,
    output logic cpu_nmi_request,
    output logic system_power_on
);
    // synchronised pin views
    pm_iobus_t bus_s;
    pm_misc_t misc_a;
    pm_misc_t misc_s;
    logic [LINES-1:0] pins_s;

    // bus strobe history
    logic rd_n_q;
    logic rd_n_d;
    logic wr_n_q;
    logic wr_n_d;
    logic rd_go;
    logic wr_go;
    logic wr_data;
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rdata_oe_n_q;
    logic rdata_oe_n_d;

    // line registers
    logic [LINES-1:0] oe_n_q;
    logic [LINES-1:0] oe_n_d;
    logic [LINES-1:0] out_q;
    logic [LINES-1:0] out_d;

    // power management registers
    logic [7:0] nmi_en_q;
    logic [7:0] nmi_en_d;
    logic tmr_en_q;
    logic tmr_en_d;
    logic ring_en_q;
    logic ring_en_d;
    logic sys_on_q;
    logic sys_on_d;
    logic tmr_flag_q;
    logic tmr_flag_d;
    logic ring_flag_q;
    logic ring_flag_d;
    logic [15:0] tmr_lim_q;
    logic [15:0] tmr_lim_d;
    logic [7:0] ring_thr_q;
    logic [7:0] ring_thr_d;
    logic nmi_q;
    logic nmi_d;

    // event edges
    logic minute_q;
    logic minute_d;
    logic ring_q;
    logic ring_d;
    logic minute_rise;
    logic ring_fall;
    logic tmr_fire;
    logic ring_fire;
    logic tmr_clear;
    logic ring_clear;
    logic [NMI_LINES-1:0] line_nmi;

    // synchroniser flush guard
    logic [1:0] arm_q;
    logic [1:0] arm_d;
    logic armed;

    function automatic logic hit_idx(input logic [7:0] idx, input logic [7:0] want);
        hit_idx = (idx == want);
    endfunction

    assign misc_a.ext_a = ext_nmi_in_a;
    assign misc_a.ext_b = ext_nmi_in_b;
    assign misc_a.minute = minute_tick;
    assign misc_a.ring_n = ring_in_n;

    pm_sync #(
        .W($bits(pm_iobus_t))
    ) u_sync_bus (
        .clock(clock),
        .rstn(rstn),
        .async_in(io_bus),
        .sync_out(bus_s)
    );

    pm_sync #(
        .W($bits(pm_misc_t))
    ) u_sync_misc (
        .clock(clock),
        .rstn(rstn),
        .async_in(misc_a),
        .sync_out(misc_s)
    );

    pm_sync #(
        .W(LINES)
    ) u_sync_pins (
        .clock(clock),
        .rstn(rstn),
        .async_in(power_ctl_line_in),
        .sync_out(pins_s)
    );

    // edges are ignored until the synchronisers hold pin values again,
    // so their reset contents never look like a strobe or a ring
    always_comb begin
        arm_d = rstn ? {arm_q[0], 1'b1} : 2'b00;
        armed = arm_q[1];
    end

    always_ff @(posedge clock) begin
        arm_q <= arm_d;
    end

    // strobe edges on the synchronised bus
    always_comb begin
        rd_n_d = (rstn && armed) ? bus_s.rd_n : 1'b1;
        wr_n_d = (rstn && armed) ? bus_s.wr_n : 1'b1;
        rd_go = armed && bus_s.cs && rd_n_q && !bus_s.rd_n;
        wr_go = armed && bus_s.cs && wr_n_q && !bus_s.wr_n;
        wr_data = wr_go && bus_s.addr;
    end

    always_ff @(posedge clock) begin
        rd_n_q <= rd_n_d;
        wr_n_q <= wr_n_d;
    end

    always_comb begin
        minute_d = (rstn && armed) ? misc_s.minute : 1'b0;
        ring_d = (rstn && armed) ? misc_s.ring_n : 1'b1;
        minute_rise = armed && misc_s.minute && !minute_q;
        ring_fall = armed && !misc_s.ring_n && ring_q;
    end

    always_ff @(posedge clock) begin
        minute_q <= minute_d;
        ring_q <= ring_d;
    end

    // a rewrite of a limit restarts its count
    always_comb begin
        tmr_clear = wr_data && (hit_idx(index_q, IDX_TMR_LO) || hit_idx(index_q, IDX_TMR_HI));
        ring_clear = wr_data && hit_idx(index_q, IDX_RING_THR);
    end

    pm_evt_cnt #(
        .W(16),
        .STRICT(1'b0)
    ) u_tmr (
        .clock(clock),
        .rstn(rstn),
        .clear(tmr_clear),
        .enable(tmr_en_q),
        .event_pulse(minute_rise),
        .limit(tmr_lim_q),
        .fire(tmr_fire)
    );

    pm_evt_cnt #(
        .W(RING_W),
        .STRICT(1'b1)
    ) u_ring (
        .clock(clock),
        .rstn(rstn),
        .clear(ring_clear),
        .enable(ring_en_q),
        .event_pulse(ring_fall),
        .limit(ring_thr_q),
        .fire(ring_fire)
    );

    // register writes
    always_comb begin
        index_d = index_q;
        oe_n_d = oe_n_q;
        out_d = out_q;
        nmi_en_d = nmi_en_q;
        tmr_en_d = tmr_en_q;
        ring_en_d = ring_en_q;
        sys_on_d = sys_on_q;
        tmr_flag_d = tmr_flag_q;
        ring_flag_d = ring_flag_q;
        tmr_lim_d = tmr_lim_q;
        ring_thr_d = ring_thr_q;
        if (wr_go && !bus_s.addr) begin
            index_d = bus_s.wdata;
        end
        if (wr_data) begin
            unique case (index_q)
                IDX_DIR_LO: oe_n_d[7:0] = ~bus_s.wdata;
                IDX_OUT_LO: out_d[7:0] = bus_s.wdata;
                IDX_DIR_HI: oe_n_d[15:8] = ~bus_s.wdata;
                IDX_OUT_HI: out_d[15:8] = bus_s.wdata;
                IDX_NMI_EN: nmi_en_d = bus_s.wdata;
                IDX_PWR_CTL: begin
                    tmr_en_d = bus_s.wdata[PC_TMR_EN];
                    ring_en_d = bus_s.wdata[PC_RING_EN];
                    sys_on_d = bus_s.wdata[PC_SYS_ON];
                    if (bus_s.wdata[PC_TMR_FLAG]) begin
                        tmr_flag_d = 1'b0;
                    end
                    if (bus_s.wdata[PC_RING_FLAG]) begin
                        ring_flag_d = 1'b0;
                    end
                end
                IDX_TMR_LO: tmr_lim_d[7:0] = bus_s.wdata;
                IDX_TMR_HI: tmr_lim_d[15:8] = bus_s.wdata;
                IDX_RING_THR: ring_thr_d = bus_s.wdata;
                default: ;
            endcase
        end
        // wake events power on, set wins
        if (tmr_fire) begin
            tmr_flag_d = 1'b1;
            sys_on_d = 1'b1;
        end
        if (ring_fire) begin
            ring_flag_d = 1'b1;
            sys_on_d = 1'b1;
        end
        if (!rstn) begin
            index_d = RST_REG;
            oe_n_d = {RST_OE_N, RST_OE_N};
            out_d = {RST_REG, RST_REG};
            nmi_en_d = RST_REG;
            tmr_en_d = 1'b0;
            ring_en_d = 1'b0;
            sys_on_d = 1'b0;
            tmr_flag_d = 1'b0;
            ring_flag_d = 1'b0;
            tmr_lim_d = {RST_REG, RST_REG};
            ring_thr_d = RST_REG;
        end
    end

    always_ff @(posedge clock) begin
        index_q <= index_d;
        oe_n_q <= oe_n_d;
        out_q <= out_d;
        nmi_en_q <= nmi_en_d;
        tmr_en_q <= tmr_en_d;
        ring_en_q <= ring_en_d;
        sys_on_q <= sys_on_d;
        tmr_flag_q <= tmr_flag_d;
        ring_flag_q <= ring_flag_d;
        tmr_lim_q <= tmr_lim_d;
        ring_thr_q <= ring_thr_d;
    end

    // read data, driven while the read strobe is held
    always_comb begin
        rdata_d = rdata_q;
        rdata_oe_n_d = !(bus_s.cs && !bus_s.rd_n);
        if (rd_go) begin
            if (!bus_s.addr) begin
                rdata_d = index_q;
            end else begin
                unique case (index_q)
                    IDX_DIR_LO: rdata_d = ~oe_n_q[7:0];
                    IDX_OUT_LO: rdata_d = out_q[7:0];
                    IDX_IN_LO: rdata_d = pins_s[7:0];
                    IDX_DIR_HI: rdata_d = ~oe_n_q[15:8];
                    IDX_OUT_HI: rdata_d = out_q[15:8];
                    IDX_IN_HI: rdata_d = pins_s[15:8];
                    IDX_NMI_EN: rdata_d = nmi_en_q;
                    IDX_PWR_CTL: begin
                        rdata_d = RST_REG;
                        rdata_d[PC_TMR_EN] = tmr_en_q;
                        rdata_d[PC_RING_EN] = ring_en_q;
                        rdata_d[PC_SYS_ON] = sys_on_q;
                        rdata_d[PC_TMR_FLAG] = tmr_flag_q;
                        rdata_d[PC_RING_FLAG] = ring_flag_q;
                    end
                    IDX_TMR_LO: rdata_d = tmr_lim_q[7:0];
                    IDX_TMR_HI: rdata_d = tmr_lim_q[15:8];
                    IDX_RING_THR: rdata_d = ring_thr_q;
                    default: rdata_d = RST_REG;
                endcase
            end
        end
        if (!rstn) begin
            rdata_d = RST_REG;
            rdata_oe_n_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        rdata_q <= rdata_d;
        rdata_oe_n_q <= rdata_oe_n_d;
    end

    // nmi combining
    always_comb begin
        for (int i = 0; i < NMI_LINES; i++) begin
            line_nmi[i] = nmi_en_q[NMI_LINE0 + i] && !pins_s[NMI_LINE_BASE + i];
        end
        nmi_d = (nmi_en_q[NMI_EXT_A] && misc_s.ext_a)
            || (nmi_en_q[NMI_EXT_B] && misc_s.ext_b)
            || (|line_nmi)
            || (nmi_en_q[NMI_TMR] && tmr_flag_q)
            || (nmi_en_q[NMI_RING] && ring_flag_q);
        if (!rstn) begin
            nmi_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        nmi_q <= nmi_d;
    end

    assign power_ctl_line_oe_n = oe_n_q;
    assign power_ctl_line_out = out_q;
    assign io_rdata = rdata_q;
    assign io_rdata_oe_n = rdata_oe_n_q;
    assign cpu_nmi_request = nmi_q;
    assign system_power_on = sys_on_q;
endmodule

// >>> logic/pm_pkg.sv
// constants and types for the power control and status lines block
// Summary of operation
// - sixteen lines, each input or output
// - low bank: bit n is line n
// - low direction at 48h, 1 means output
// - low output at 49h, 1 drives high
// - low input status at 4Ah, read only
// - high bank: bit n is line n+8
// - high direction at 4Bh, 1 means output
// - high output at 4Ch, 1 drives high
// - high input status at 4Dh, read only
// - reset clears direction and output registers
// - three status inputs may raise nmi
// - two external nmi inputs plus internal sources
// - control port selects active nmi sources
// - minute counter powers system on, eleven days; the code takes a 16-bit minute limit, up to 65535 minutes
// - ring count above threshold powers system on
// - minute tick is the counter time base
// - ring input is active low
// - power output high turns system on
// - nmi out active high, inputs ored
package pm_pkg;
    // index register offsets
    localparam logic [7:0] IDX_DIR_LO = 8'h48;
    localparam logic [7:0] IDX_OUT_LO = 8'h49;
    localparam logic [7:0] IDX_IN_LO = 8'h4a;
    localparam logic [7:0] IDX_DIR_HI = 8'h4b;
    localparam logic [7:0] IDX_OUT_HI = 8'h4c;
    localparam logic [7:0] IDX_IN_HI = 8'h4d;
    localparam logic [7:0] IDX_NMI_EN = 8'h4e;
    localparam logic [7:0] IDX_PWR_CTL = 8'h4f;
    localparam logic [7:0] IDX_TMR_LO = 8'h50;
    localparam logic [7:0] IDX_TMR_HI = 8'h51;
    localparam logic [7:0] IDX_RING_THR = 8'h52;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_OE_N = 8'hff;
    // nmi enable fields
    localparam int NMI_EXT_A = 0;
    localparam int NMI_EXT_B = 1;
    localparam int NMI_LINE0 = 2;
    localparam int NMI_TMR = 5;
    localparam int NMI_RING = 6;
    // lines that can serve as nmi status inputs
    localparam int NMI_LINE_BASE = 8;
    localparam int NMI_LINES = 3;
    // power control fields
    localparam int PC_TMR_EN = 0;
    localparam int PC_RING_EN = 1;
    localparam int PC_SYS_ON = 2;
    localparam int PC_TMR_FLAG = 3;
    localparam int PC_RING_FLAG = 4;
    // self timed interval: eleven days of minutes
    localparam int MAX_DAYS = 11;
    localparam int MAX_MINUTES = MAX_DAYS * 24 * 60;
    localparam int TMR_W = $clog2(MAX_MINUTES + 1);
    localparam int RING_W = 8;
    localparam int LINES = 16;

    // host side pins of the indexed port pair
    typedef struct packed {
        logic cs;
        logic addr;
        logic rd_n;
        logic wr_n;
        logic [7:0] wdata;
    } pm_iobus_t;

    // other asynchronous inputs
    typedef struct packed {
        logic ext_a;
        logic ext_b;
        logic minute;
        logic ring_n;
    } pm_misc_t;
endpackage

// >>> logic/pm_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module pm_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = rstn ? async_in : '0;
        sync_d = rstn ? meta_q : '0;
    end

    always_ff @(posedge clock) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;
endmodule

// >>> logic/pm_evt_cnt.sv
// event counter that fires once when its count reaches a limit, or passes it when STRICT is set
`timescale 1ns/1ps
module pm_evt_cnt #(
    parameter int W = 8,
    parameter bit STRICT = 1'b0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clear,
    input wire logic enable,
    input wire logic event_pulse,
    input wire logic [W-1:0] limit,
    output logic fire
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic done_q;
    logic done_d;
    logic fire_q;
    logic fire_d;
    logic [W-1:0] nxt;
    logic hit;

    always_comb begin
        nxt = (cnt_q == '1) ? cnt_q : W'(cnt_q + 1'b1);
        hit = STRICT ? (nxt > limit) : (nxt >= limit);
        cnt_d = cnt_q;
        done_d = done_q;
        fire_d = 1'b0;
        if (!rstn || clear || !enable) begin
            cnt_d = '0;
            done_d = 1'b0;
        end else if (event_pulse) begin
            cnt_d = nxt;
            if (hit && !done_q) begin
                fire_d = 1'b1;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        cnt_q <= cnt_d;
        done_q <= done_d;
        fire_q <= fire_d;
    end

    assign fire = fire_q;
endmodule

// >>> test/pm_lines_props.sv
// concurrent checks on the ports of the power control lines block
`timescale 1ns/1ps
module pm_lines_props
    import pm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire pm_iobus_t io_bus,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe_n,
    input wire logic [LINES-1:0] power_ctl_line_in,
    input wire logic [LINES-1:0] power_ctl_line_out,
    input wire logic [LINES-1:0] power_ctl_line_oe_n,
    input wire logic ext_nmi_in_a,
    input wire logic ext_nmi_in_b,
    input wire logic minute_tick,
    input wire logic ring_in_n,
    input wire logic cpu_nmi_request,
    input wire logic system_power_on
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    AST_RST_LINES: assert property (disable iff (1'b0)
        !rstn |=> power_ctl_line_oe_n == {LINES{1'b1}} && power_ctl_line_out == '0)
        else $error("lines not cleared by reset");
    AST_RST_OUTS: assert property (disable iff (1'b0)
        !rstn |=> !system_power_on && !cpu_nmi_request && io_rdata_oe_n && io_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    AST_DIR_HOLD: assert property (io_bus.wr_n [*5] |-> $stable(power_ctl_line_oe_n))
        else $error("direction changed without a write");
    AST_OUT_HOLD: assert property (io_bus.wr_n [*5] |-> $stable(power_ctl_line_out))
        else $error("output levels changed without a write");
    AST_RDOE_ON: assert property ((io_bus.cs && !io_bus.rd_n) [*5] |-> !io_rdata_oe_n)
        else $error("read data not driven during read");
    AST_RDOE_OFF: assert property (io_bus.rd_n [*5] |-> io_rdata_oe_n)
        else $error("read data driven without read");
    AST_RDATA_HOLD: assert property (io_bus.rd_n [*5] |-> $stable(io_rdata))
        else $error("read data changed without read");
    AST_PWR_HOLD: assert property ((system_power_on && io_bus.wr_n) [*5] |=> system_power_on)
        else $error("system power dropped without a write");
    AST_PWR_QUIET: assert property (
        (!system_power_on && io_bus.wr_n && $stable(minute_tick) && $stable(ring_in_n)) [*8]
        |=> !system_power_on)
        else $error("system power rose without a cause");
endmodule

// >>> test/pm_switches.sv
// peripheral switches on the far side of the power control lines
`timescale 1ns/1ps
module pm_switches
    import pm_pkg::*;
(
    input wire logic [LINES-1:0] line_out,
    input wire logic [LINES-1:0] line_oe_n,
    input wire logic [LINES-1:0] ext_lvl,
    output logic [LINES-1:0] line_pin
);
    // an undriven line shows the switch's own status level
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            line_pin[i] = line_oe_n[i] ? ext_lvl[i] : line_out[i];
        end
    end
endmodule

// >>> test/power_control_status_lines_test.sv
// self-checking bench for the power control lines block
`timescale 1ns/1ps
module power_control_status_lines_test;
    import pm_pkg::*;
    logic clock;
    logic rstn;
    pm_iobus_t io_bus;
    logic [7:0] io_rdata, rb, rh, rd_byte;
    logic io_rdata_oe_n, ext_a, ext_b, minute, ring_n, nmi, pwr;
    logic [LINES-1:0] line_pin, line_out, line_oe_n, ext_lvl, dir, outv;
    int fails, total_checks;
    integer seed;
    logic [7:0] regs [4] = '{IDX_DIR_LO, IDX_OUT_LO, IDX_DIR_HI, IDX_OUT_HI};

    pm_lines uut (.clock(clock), .rstn(rstn), .io_bus(io_bus), .io_rdata(io_rdata),
        .io_rdata_oe_n(io_rdata_oe_n), .power_ctl_line_in(line_pin), .power_ctl_line_out(line_out),
        .power_ctl_line_oe_n(line_oe_n), .ext_nmi_in_a(ext_a), .ext_nmi_in_b(ext_b),
        .minute_tick(minute), .ring_in_n(ring_n), .cpu_nmi_request(nmi), .system_power_on(pwr));
    pm_switches sw (.line_out(line_out), .line_oe_n(line_oe_n), .ext_lvl(ext_lvl), .line_pin(line_pin));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // one strobe on the indexed pair; read data taken while strobe held
    task automatic strobe(input logic a, input logic rd, input logic [7:0] d);
        io_bus.cs = 1'b1;
        io_bus.addr = a;
        io_bus.wdata = d;
        cyc(2);
        if (rd) io_bus.rd_n = 1'b0;
        else io_bus.wr_n = 1'b0;
        cyc(6);
        rd_byte = io_rdata;
        io_bus.rd_n = 1'b1;
        io_bus.wr_n = 1'b1;
        io_bus.cs = 1'b0;
        cyc(5);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        strobe(1'b0, 1'b0, idx);
        strobe(1'b1, 1'b0, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        strobe(1'b0, 1'b0, idx);
        strobe(1'b1, 1'b1, 8'h00);
        v = rd_byte;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] pin_exp(input logic [15:0] d, input logic [15:0] o, input logic [15:0] e);
        return (d & o) | (~d & e);
    endfunction

    task automatic trig(input int i, input logic on);
        if (i == 0) ext_a = on;
        else if (i == 1) ext_b = on;
        else ext_lvl[NMI_LINE_BASE + i - 2] = ~on;
    endtask

    task automatic pulse(input int m);
        if (m == 0) minute = 1'b1;
        else ring_n = 1'b0;
        cyc(5);
        minute = 1'b0;
        ring_n = 1'b1;
        cyc(5);
    endtask

    task automatic complete_run;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 40000);
        fails++;
        complete_run();
    end

    initial begin
        seed = 32'hdb2d;
        fails = 0;
        total_checks = 0;
        io_bus = '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
        ext_lvl = 16'hffff;
        ext_a = 1'b0;
        ext_b = 1'b0;
        minute = 1'b0;
        ring_n = 1'b1;
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
        cyc(1);
        chk(line_oe_n, 16'hffff);
        foreach (regs[i]) begin
            rd(regs[i], rb);
            chk(rb, 16'h0000);
        end
        for (int k = 0; k < 8; k++) begin
            dir = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
            outv = (k == 1) ? 16'hffff : 16'($random(seed));
            ext_lvl = (k == 1) ? 16'h0000 : 16'($random(seed));
            wr(IDX_DIR_LO, dir[7:0]);
            wr(IDX_OUT_LO, outv[7:0]);
            wr(IDX_DIR_HI, dir[15:8]);
            wr(IDX_OUT_HI, outv[15:8]);
            chk(line_oe_n, ~dir);
            chk(line_out, outv);
            rd(IDX_IN_LO, rb);
            rd(IDX_IN_HI, rh);
            chk({rh, rb}, pin_exp(dir, outv, ext_lvl));
            rd(IDX_DIR_HI, rh);
            rd(IDX_DIR_LO, rb);
            chk({rh, rb}, dir);
            rd(IDX_OUT_HI, rh);
            rd(IDX_OUT_LO, rb);
            chk({rh, rb}, outv);
        end
        wr(IDX_IN_LO, ~rb);
        chk(line_out, outv);
        rd(8'h60, rb);
        chk(rb, 16'h0000);
        wr(IDX_DIR_LO, 8'h00);
        wr(IDX_DIR_HI, 8'h00);
        ext_lvl = 16'hffff;
        for (int i = 0; i < 5; i++) begin
            wr(IDX_NMI_EN, 8'h00);
            trig(i, 1'b1);
            cyc(6);
            chk(nmi, 16'h0000);
            wr(IDX_NMI_EN, 8'h01 << i);
            chk(nmi, 16'h0001);
            trig(i, 1'b0);
            cyc(6);
            chk(nmi, 16'h0000);
        end
        wr(IDX_NMI_EN, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(IDX_PWR_CTL, 8'h18);
            wr(m ? IDX_RING_THR : IDX_TMR_LO, m ? 8'h02 : 8'h03);
            wr(IDX_PWR_CTL, m ? 8'h02 : 8'h01);
            repeat (3) begin
                chk(pwr, 16'h0000);
                pulse(m);
            end
            cyc(2);
            chk(pwr, 16'h0001);
            // the wake flag of this mode reaches the nmi output once enabled
            wr(IDX_NMI_EN, m ? (8'h01 << NMI_RING) : (8'h01 << NMI_TMR));
            chk(nmi, 16'h0001);
            wr(IDX_PWR_CTL, 8'h18);
            chk(nmi, 16'h0000);
            chk(pwr, 16'h0000);
            wr(IDX_NMI_EN, 8'h00);
        end
        wr(IDX_PWR_CTL, 8'h18);
        chk(pwr, 16'h0000);
        wr(IDX_DIR_LO, 8'hff);
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
        cyc(1);
        chk(line_oe_n, 16'hffff);
        chk(line_out, 16'h0000);
        rd(IDX_DIR_LO, rb);
        chk(rb, 16'h0000);
        complete_run();
    end
endmodule

bind pm_lines pm_lines_props props (.clock(clock), .rstn(rstn), .io_bus(io_bus), .io_rdata(io_rdata),
    .io_rdata_oe_n(io_rdata_oe_n), .power_ctl_line_in(power_ctl_line_in),
    .power_ctl_line_out(power_ctl_line_out), .power_ctl_line_oe_n(power_ctl_line_oe_n),
    .ext_nmi_in_a(ext_nmi_in_a), .ext_nmi_in_b(ext_nmi_in_b), .minute_tick(minute_tick),
    .ring_in_n(ring_in_n), .cpu_nmi_request(cpu_nmi_request), .system_power_on(system_power_on));
